// >>> hw/mrdc_codec.sv
// Purpose: packs values into 16-bit registers and streams them as bytes
// Assumes: one clock, value and control ports synchronous to it
// Notes:   also maps bit addresses and keeps retained register copies
`timescale 1ns/100ps
`include "mrdc_defines.svh"
module mrdc_codec
   import mrdc_pkg::*;
#(
   parameter int NREG = 8
)(
   // clock and reset
   input  wire logic                    CORE_CLK,
   input  wire logic                    RST_N,
   // value to pack
   input  wire logic                    PACK_GO,
   input  wire mrdc_kind_type           PACK_KIND,
   input  wire mrdc_scale_type          PACK_SCALE,
   input  wire logic [63:0]             PACK_VALUE,
   // byte stream out
   output logic                         TX_VALID,
   output logic [7:0]                   TX_BYTE,
   output logic                         TX_LAST,
   output logic [2:0]                   PACK_WORDS,
   output logic                         PACK_BAD,
   // received register to unpack
   input  wire logic                    RX_GO,
   input  wire logic [1:0]              RX_WORD_IDX,
   input  wire logic [15:0]             RX_WORD,
   output logic [15:0]                  RX_CLEAN,
   // address translation and bit access check
   input  wire logic                    ADDR_GO,
   input  wire logic [15:0]             REG_NUMBER,
   input  wire logic [3:0]              BIT_NUMBER,
   input  wire logic [7:0]              FUNC_CODE,
   input  wire logic                    REG_IS_BITMAP,
   output logic [15:0]                  LINK_ADDR,
   output logic [15:0]                  BIT_ADDR,
   output logic                         BIT_OK,
   output logic                         HOLD_READ,
   // retention store
   input  wire logic                    POWER_LOSS,
   input  wire logic                    STORE_WE,
   input  wire logic [$clog2(NREG)-1:0] STORE_IDX,
   input  wire logic [15:0]             STORE_DATA,
   input  wire logic [NREG-1:0]         RETAIN_MASK,
   output logic [15:0]                  STORE_Q
);

   localparam int IDXW = $clog2(NREG);

   // store index must cover every entry and no more
   if ((NREG < 2) || ((NREG & (NREG - 1)) != 0)) begin : g_bad_nreg
      $error("NREG must be a power of two, at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // scaling and word packing
   wire logic [63:0] times10_w = {PACK_VALUE[60:0], 3'b000} + {PACK_VALUE[62:0], 1'b0};
   wire logic [63:0] tenth_w   = PACK_VALUE / 64'h0000_0000_0000_000A;
   wire logic [63:0] scaled_w  = (PACK_SCALE == MRDC_SCALE_10)    ? times10_w :
                                 (PACK_SCALE == MRDC_SCALE_TENTH) ? tenth_w : PACK_VALUE;
   wire logic [2:0]  nwords_w  = (PACK_KIND inside {MRDC_INT64, MRDC_UINT64, MRDC_DATETIME}) ? 3'h4 :
                                 (PACK_KIND inside {MRDC_INT32, MRDC_UINT32, MRDC_FLOAT32}) ? 3'h2 : 3'h1;
   // date words: first word is year, last is milliseconds
   wire logic [15:0] dt_w1 = scaled_w[63:48] & `MRDC_YEAR_MASK;
   wire logic [15:0] dt_w2 = scaled_w[47:32] & `MRDC_DAYMON_MASK;
   wire logic [15:0] dt_w3 = scaled_w[31:16] & `MRDC_MINHR_MASK;
   wire logic [15:0] dt_w4 = scaled_w[15:0];
   wire logic        dt_bad = (dt_w4 > `MRDC_MS_MAX)
                            || (dt_w3[`MRDC_MIN_MSB:`MRDC_MIN_LSB] > `MRDC_MIN_MAX)
                            || (dt_w3[`MRDC_HOUR_MSB:`MRDC_HOUR_LSB] > `MRDC_HOUR_MAX)
                            || (dt_w2[`MRDC_MON_MSB:`MRDC_MON_LSB] > `MRDC_MON_MAX)
                            || (dt_w2[`MRDC_DAY_MSB:`MRDC_DAY_LSB] < `MRDC_DAY_MIN);
   wire logic [7:0]  fp_exp = scaled_w[30:23];
   wire logic        fp_bad = (fp_exp == `MRDC_FP_EXP_ZERO) || (fp_exp == `MRDC_FP_EXP_ONES);
   // ascii: earlier char in value low byte goes to register low byte
   wire logic [15:0] chars_w = {scaled_w[15:8], scaled_w[7:0]};
   // words left-justified so the most significant word leaves first
   wire logic [63:0] words_w =
      (PACK_KIND == MRDC_DATETIME) ? {dt_w1, dt_w2, dt_w3, dt_w4} :
      (nwords_w == 3'h4) ? scaled_w :
      (nwords_w == 3'h2) ? {scaled_w[31:0], 32'h0000_0000} :
      (PACK_KIND == MRDC_ASCII) ? {chars_w, 48'h0000_0000_0000} :
                           {scaled_w[15:0], 48'h0000_0000_0000};
   wire logic        bad_w = ((PACK_KIND == MRDC_DATETIME) && dt_bad)
                          || ((PACK_KIND == MRDC_FLOAT32) && fp_bad);

   ////////////////////////////////////////////////////////////////////////////
   // byte serialiser
   mrdc_state_type  state_r, state_nxt;
   logic [63:0]     shift_r, shift_nxt;
   logic [3:0]      left_r, left_nxt;
   wire logic       start_w = (state_r == MRDC_ST_IDLE) && PACK_GO && !bad_w;

   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      left_nxt  = left_r;
      case (state_r)
         MRDC_ST_IDLE: begin
            if (start_w) begin
               state_nxt = MRDC_ST_SEND;
               shift_nxt = words_w;
               left_nxt  = {nwords_w, 1'b0};
            end
         end
         MRDC_ST_SEND: begin
            shift_nxt = {shift_r[55:0], 8'h00};
            left_nxt  = left_r - 4'h1;
            if (left_r == 4'h1) begin
               state_nxt = MRDC_ST_IDLE;
            end
         end
         default: begin
            state_nxt = MRDC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= MRDC_ST_IDLE;
         shift_r <= 64'h0000_0000_0000_0000;
         left_r  <= 4'h0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         left_r  <= left_nxt;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         TX_VALID   <= 1'b0;
         TX_BYTE    <= 8'h00;
         TX_LAST    <= 1'b0;
         PACK_WORDS <= 3'h0;
         PACK_BAD   <= 1'b0;
      end else begin
         TX_VALID   <= (state_r == MRDC_ST_SEND);
         TX_BYTE    <= shift_r[63:56];
         TX_LAST    <= (state_r == MRDC_ST_SEND) && (left_r == 4'h1);
         PACK_WORDS <= start_w ? nwords_w : PACK_WORDS;
         PACK_BAD   <= PACK_GO && bad_w && (state_r == MRDC_ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // received words: reserved date bits dropped
   wire logic [15:0] rx_mask_w = (RX_WORD_IDX == 2'h0) ? `MRDC_YEAR_MASK :
                                 (RX_WORD_IDX == 2'h1) ? `MRDC_DAYMON_MASK :
                                 (RX_WORD_IDX == 2'h2) ? `MRDC_MINHR_MASK : 16'hFFFF;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RX_CLEAN <= 16'h0000;
      end else if (RX_GO) begin
         RX_CLEAN <= RX_WORD & rx_mask_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address translation
   wire logic [15:0] addr_w    = REG_NUMBER - 16'h0001;
   wire logic [15:0] bitaddr_w = {addr_w[11:0], BIT_NUMBER};
   wire logic        fc_bit_w  = (FUNC_CODE == `MRDC_FC_RD_COILS) || (FUNC_CODE == `MRDC_FC_RD_DISC)
                              || (FUNC_CODE == `MRDC_FC_WR_COIL) || (FUNC_CODE == `MRDC_FC_WR_COILS);
   wire logic        bit_ok_w  = REG_IS_BITMAP && fc_bit_w && (addr_w <= `MRDC_BITADDR_MAX);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         LINK_ADDR <= 16'h0000;
         BIT_ADDR  <= 16'h0000;
         BIT_OK    <= 1'b0;
         HOLD_READ <= 1'b0;
      end else if (ADDR_GO) begin
         LINK_ADDR <= addr_w;
         BIT_ADDR  <= bitaddr_w;
         BIT_OK    <= bit_ok_w;
         HOLD_READ <= (FUNC_CODE == `MRDC_FC_RD_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // retention store: unflagged entries clear on power loss or reset
   logic [15:0] store_r [NREG];
   logic [15:0] saved_r [NREG];
   logic        restore_r;

   for (genvar i = 0; i < NREG; i++) begin : g_reg
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
         if (!RST_N) begin
            store_r[i] <= 16'h0000;
         end else if (STORE_WE && (STORE_IDX == IDXW'(i))) begin
            store_r[i] <= STORE_DATA;
         end else if (POWER_LOSS || restore_r) begin
            store_r[i] <= RETAIN_MASK[i] ? saved_r[i] : 16'h0000;
         end
      end
      // backing copy kept without reset, as nonvolatile storage would be
      always_ff @(posedge CORE_CLK) begin
         if (STORE_WE && (STORE_IDX == IDXW'(i)) && RETAIN_MASK[i]) begin
            saved_r[i] <= STORE_DATA;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         restore_r <= 1'b1;
         STORE_Q   <= 16'h0000;
      end else begin
         restore_r <= 1'b0;
         STORE_Q   <= (restore_r && RETAIN_MASK[STORE_IDX]) ? saved_r[STORE_IDX] : store_r[STORE_IDX];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   tx_order_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w |-> ##2 (TX_BYTE == $past(words_w[63:56], 2)) ##1 (TX_BYTE == $past(words_w[55:48], 3)))
      else $error("high byte not sent first");
   word_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (nwords_w == 3'h2) |-> ##1 (left_r == 4'h4))
      else $error("wrong byte count for two-word value");
   frame_len_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (nwords_w == 3'h4) |-> ##1 (state_r == MRDC_ST_SEND) [*8] ##1 (state_r == MRDC_ST_IDLE))
      else $error("64-bit frame length wrong");
   half_order_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (PACK_KIND == MRDC_UINT32) && (PACK_SCALE == MRDC_SCALE_1) |-> ##1 (shift_r[63:48] == $past(PACK_VALUE[31:16])))
      else $error("upper half not in first register");
   year_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (PACK_KIND == MRDC_DATETIME) |-> ##1 (shift_r[63:55] == 9'h000))
      else $error("year reserved bits not zero");
   rx_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      RX_GO && (RX_WORD_IDX == 2'h2) |=> (RX_CLEAN[15:13] == 3'h0) && (RX_CLEAN[7:6] == 2'h0))
      else $error("reserved date bits leaked");
   bit_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ADDR_GO |=> (BIT_ADDR[3:0] == $past(BIT_NUMBER)) && (BIT_ADDR[15:4] == $past(addr_w[11:0])))
      else $error("bit address wrong");
   bit_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ADDR_GO && !REG_IS_BITMAP |=> !BIT_OK)
      else $error("bit access allowed on non-bitmap");
   link_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ADDR_GO |=> (LINK_ADDR + 16'h0001 == $past(REG_NUMBER)))
      else $error("link address not number minus one");
   float_rej_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PACK_GO && (state_r == MRDC_ST_IDLE) && (PACK_KIND == MRDC_FLOAT32) && fp_bad |=> PACK_BAD && !TX_VALID)
      else $error("denormal float not refused");
   ms_rej_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PACK_GO && (state_r == MRDC_ST_IDLE) && (PACK_KIND == MRDC_DATETIME) && (PACK_SCALE == MRDC_SCALE_1)
      && (PACK_VALUE[15:0] > `MRDC_MS_MAX) |=> PACK_BAD && (state_r == MRDC_ST_IDLE))
      else $error("milliseconds out of range sent");
   hour_rej_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PACK_GO && (state_r == MRDC_ST_IDLE) && (PACK_KIND == MRDC_DATETIME) && (PACK_SCALE == MRDC_SCALE_1)
      && (PACK_VALUE[28:24] > `MRDC_HOUR_MAX) |=> PACK_BAD && (state_r == MRDC_ST_IDLE))
      else $error("hour out of range sent");
   day_rej_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PACK_GO && (state_r == MRDC_ST_IDLE) && (PACK_KIND == MRDC_DATETIME) && (PACK_SCALE == MRDC_SCALE_1)
      && (PACK_VALUE[36:32] < `MRDC_DAY_MIN) |=> PACK_BAD && (state_r == MRDC_ST_IDLE))
      else $error("day zero sent");
   tx_run_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      TX_VALID && !TX_LAST |=> TX_VALID)
      else $error("byte stream broken inside a value");
   two_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (PACK_KIND inside {MRDC_INT32, MRDC_UINT32, MRDC_FLOAT32})
      |-> ##1 (state_r == MRDC_ST_SEND) [*4] ##1 (state_r == MRDC_ST_IDLE))
      else $error("two-word frame length wrong");
   one_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (PACK_KIND inside {MRDC_INT16, MRDC_UINT16, MRDC_ASCII, MRDC_BITMAP})
      |-> ##1 (state_r == MRDC_ST_SEND) [*2] ##1 (state_r == MRDC_ST_IDLE))
      else $error("one-word frame length wrong");
   ascii_order_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_w && (PACK_KIND == MRDC_ASCII) && (PACK_SCALE == MRDC_SCALE_1)
      |-> ##1 (shift_r[55:48] == $past(PACK_VALUE[7:0])) && (shift_r[63:56] == $past(PACK_VALUE[15:8])))
      else $error("character pair order wrong");
   float_ok_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PACK_GO && (state_r == MRDC_ST_IDLE) && (PACK_KIND == MRDC_FLOAT32) && (PACK_SCALE == MRDC_SCALE_1)
      && (PACK_VALUE[30:23] != `MRDC_FP_EXP_ZERO) && (PACK_VALUE[30:23] != `MRDC_FP_EXP_ONES)
      |=> (state_r == MRDC_ST_SEND) && !PACK_BAD)
      else $error("normalized float refused");
   rx_year_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      RX_GO && (RX_WORD_IDX == 2'h0) |=> (RX_CLEAN[15:7] == 9'h000))
      else $error("year reserved bits leaked");
   rx_daymon_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      RX_GO && (RX_WORD_IDX == 2'h1) |=> (RX_CLEAN[15:12] == 4'h0) && (RX_CLEAN[7:5] == 3'h0))
      else $error("day and month reserved bits leaked");
   fc_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ADDR_GO && !(FUNC_CODE inside {`MRDC_FC_RD_COILS, `MRDC_FC_RD_DISC, `MRDC_FC_WR_COIL, `MRDC_FC_WR_COILS})
      |=> !BIT_OK)
      else $error("bit access allowed for wrong function");
   bit_range_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ADDR_GO && (REG_NUMBER > 16'h1000) |=> !BIT_OK)
      else $error("bit access allowed above bit address range");
   retain_clr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      POWER_LOSS && !STORE_WE && !RETAIN_MASK[STORE_IDX] ##1 $stable(STORE_IDX) |=> (STORE_Q == 16'h0000))
      else $error("unretained entry survived power loss");

endmodule

// >>> hw/mrdc_defines.svh
// Purpose: constants for the register data codec
// Assumes: 16-bit registers, big endian link order
// Notes:   included by the codec; the package does not include it
`ifndef MRDC_DEFINES_SVH
`define MRDC_DEFINES_SVH
`define MRDC_YEAR_LSB      0
`define MRDC_YEAR_MSB      6
`define MRDC_DAY_LSB       0
`define MRDC_DAY_MSB       4
`define MRDC_MON_LSB       8
`define MRDC_MON_MSB       11
`define MRDC_MIN_LSB       0
`define MRDC_MIN_MSB       5
`define MRDC_HOUR_LSB      8
`define MRDC_HOUR_MSB      12
`define MRDC_YEAR_MASK     16'h007F
`define MRDC_DAYMON_MASK   16'h0F1F
`define MRDC_MINHR_MASK    16'h1F3F
`define MRDC_MS_MAX        16'hEA5F
`define MRDC_MIN_MAX       6'h3B
`define MRDC_HOUR_MAX      5'h17
`define MRDC_MON_MAX       4'hC
`define MRDC_DAY_MIN       5'h01
`define MRDC_BITADDR_MAX   16'h0FFF
`define MRDC_BIT_SHIFT     4
`define MRDC_FC_RD_COILS   8'h01
`define MRDC_FC_RD_DISC    8'h02
`define MRDC_FC_RD_HOLD    8'h03
`define MRDC_FC_WR_COIL    8'h05
`define MRDC_FC_WR_COILS   8'h0F
`define MRDC_FP_EXP_ZERO   8'h00
`define MRDC_FP_EXP_ONES   8'hFF
`endif

// >>> hw/mrdc_pkg.sv
// Purpose: types for the register data codec
// Assumes: constants come from mrdc_defines.svh
// Notes:   data kinds and scale selection
package mrdc_pkg;
   typedef enum logic [3:0] {
      MRDC_INT16, MRDC_UINT16, MRDC_INT32, MRDC_UINT32, MRDC_INT64, MRDC_UINT64,
      MRDC_FLOAT32, MRDC_ASCII, MRDC_BITMAP, MRDC_DATETIME
   } mrdc_kind_type;
   typedef enum logic [1:0] {
      MRDC_SCALE_1, MRDC_SCALE_10, MRDC_SCALE_TENTH
   } mrdc_scale_type;
   typedef enum logic [1:0] {
      MRDC_ST_IDLE, MRDC_ST_SEND
   } mrdc_state_type;
endpackage

// >>> verif/mrdc_client_model.sv
// Purpose: client side of the link, gathers the codec byte stream
// Assumes: bytes arrive one per cycle while tx_valid is high
// Notes:   frame is right-justified, first byte most significant
`timescale 1ns/100ps
module mrdc_client_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // byte stream from the codec
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        tx_last,
   // assembled frame
   output logic [63:0]      frame_r,
   output logic [3:0]       count_r,
   output logic             done_r
);
   logic [63:0] acc_r;
   logic [3:0]  cnt_r;
   wire  [63:0] acc_nxt = {acc_r[55:0], tx_byte};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r   <= 64'h0000_0000_0000_0000;
         cnt_r   <= 4'h0;
         frame_r <= 64'h0000_0000_0000_0000;
         count_r <= 4'h0;
         done_r  <= 1'b0;
      end else begin
         done_r <= tx_valid && tx_last;
         if (tx_valid) begin
            acc_r <= tx_last ? 64'h0000_0000_0000_0000 : acc_nxt;
            cnt_r <= tx_last ? 4'h0 : cnt_r + 4'h1;
            if (tx_last) begin
               frame_r <= acc_nxt;
               count_r <= cnt_r + 4'h1;
            end
         end
      end
   end
endmodule

// >>> verif/mrdc_codec_tb_top.sv
// Purpose: self-checking bench for the register data codec
// Assumes: default NREG, client model collects the bytes
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module mrdc_codec_tb_top
   import mrdc_pkg::*;
;
   logic           core_clk = 1'b0, rst_n = 1'b0, pack_go = 1'b0, rx_go = 1'b0, addr_go = 1'b0;
   logic           bitmap = 1'b0, power_loss = 1'b0, store_we = 1'b0;
   mrdc_kind_type  pack_kind = MRDC_UINT16;
   mrdc_scale_type pack_scale = MRDC_SCALE_1;
   logic [63:0]    pack_value = '0;
   logic [1:0]     rx_idx = '0;
   logic [15:0]    rx_word = '0, reg_num = '0, store_data = '0;
   logic [3:0]     bit_num = '0;
   logic [7:0]     func = '0;
   logic [2:0]     store_idx = '0;
   logic           tx_valid, tx_last, pack_bad, bit_ok, hold_read, done;
   logic [7:0]     tx_byte;
   logic [2:0]     pack_words;
   logic [15:0]    rx_clean, link_addr, bit_addr, store_q;
   logic [63:0]    frame;
   logic [3:0]     count;
   int             err_count = 0, num_checks = 0;
   mrdc_kind_type  bad_k [7] = '{MRDC_FLOAT32, MRDC_FLOAT32, MRDC_DATETIME, MRDC_DATETIME,
                                 MRDC_DATETIME, MRDC_DATETIME, MRDC_DATETIME};
   logic [63:0]    bad_v [7] = '{64'h0000_0000_0040_0000, 64'h0000_0000_7F80_0000, 64'h000D_0C1F_173B_EA60,
                                 64'h000D_0C1F_173C_EA5F, 64'h000D_0C1F_183B_EA5F, 64'h000D_0D1F_173B_EA5F,
                                 64'h000D_0C00_173B_EA5F};
   logic [7:0]     fcs [7] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0F, 8'h10};
   logic [15:0]    masks [4] = '{16'h007F, 16'h0F1F, 16'h1F3F, 16'hFFFF};

   always #2 core_clk = ~core_clk;

   mrdc_codec DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .PACK_GO(pack_go), .PACK_KIND(pack_kind),
      .PACK_SCALE(pack_scale), .PACK_VALUE(pack_value), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
      .TX_LAST(tx_last), .PACK_WORDS(pack_words), .PACK_BAD(pack_bad), .RX_GO(rx_go),
      .RX_WORD_IDX(rx_idx), .RX_WORD(rx_word), .RX_CLEAN(rx_clean), .ADDR_GO(addr_go),
      .REG_NUMBER(reg_num), .BIT_NUMBER(bit_num), .FUNC_CODE(func), .REG_IS_BITMAP(bitmap),
      .LINK_ADDR(link_addr), .BIT_ADDR(bit_addr), .BIT_OK(bit_ok), .HOLD_READ(hold_read),
      .POWER_LOSS(power_loss), .STORE_WE(store_we), .STORE_IDX(store_idx), .STORE_DATA(store_data),
      .RETAIN_MASK(8'h05), .STORE_Q(store_q));

   mrdc_client_model client (.core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_last(tx_last), .frame_r(frame), .count_r(count), .done_r(done));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic drive_pack(input mrdc_kind_type k, input mrdc_scale_type s, input logic [63:0] v);
      @(posedge core_clk);
      pack_go <= 1'b1;
      pack_kind <= k;
      pack_scale <= s;
      pack_value <= v;
      @(posedge core_clk);
      pack_go <= 1'b0;
   endtask

   task automatic pack(input mrdc_kind_type k, input mrdc_scale_type s, input logic [63:0] v,
                       input logic [63:0] exp, input logic [3:0] nbytes);
      bit seen;
      seen = 1'b0;
      drive_pack(k, s, v);
      for (int i = 0; i < 40 && !seen; i++) begin
         @(posedge core_clk);
         #1;
         seen = (done === 1'b1);
      end
      chk("frame_done", 64'h1, {63'h0, seen});
      chk("frame", exp, frame);
      chk("byte_count", {60'h0, nbytes}, {60'h0, count});
      chk("pack_words", {60'h0, nbytes >> 1}, {61'h0, pack_words});
   endtask

   task automatic pack_refused(input mrdc_kind_type k, input logic [63:0] v);
      bit seen;
      seen = 1'b0;
      drive_pack(k, MRDC_SCALE_1, v);
      repeat (3) begin
         #1;
         seen |= (pack_bad === 1'b1);
         @(posedge core_clk);
      end
      chk("pack_bad", 64'h1, {63'h0, seen});
   endtask

   task automatic rx(input logic [1:0] idx, input logic [15:0] w, input logic [15:0] e);
      @(posedge core_clk);
      rx_go <= 1'b1;
      rx_idx <= idx;
      rx_word <= w;
      @(posedge core_clk);
      rx_go <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("rx_clean", {48'h0, e}, {48'h0, rx_clean});
   endtask

   task automatic addr(input logic [15:0] rn, input logic [3:0] bn, input logic [7:0] fc, input logic bm);
      logic [15:0] la;
      la = rn - 16'h0001;
      @(posedge core_clk);
      addr_go <= 1'b1;
      reg_num <= rn;
      bit_num <= bn;
      func <= fc;
      bitmap <= bm;
      @(posedge core_clk);
      addr_go <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("link_addr", {48'h0, la}, {48'h0, link_addr});
      chk("bit_addr", {48'h0, la * 16'h0010 + bn}, {48'h0, bit_addr});
      chk("bit_ok", {63'h0, bm && fc inside {8'h01, 8'h02, 8'h05, 8'h0F} && la <= 16'h0FFF},
          {63'h0, bit_ok});
      chk("hold_read", {63'h0, fc == 8'h03}, {63'h0, hold_read});
   endtask

   task automatic st_wr(input logic [2:0] i, input logic [15:0] d);
      @(posedge core_clk);
      store_we <= 1'b1;
      store_idx <= i;
      store_data <= d;
      @(posedge core_clk);
      store_we <= 1'b0;
   endtask

   task automatic st_rd(input logic [2:0] i, input logic [15:0] e);
      @(posedge core_clk);
      store_idx <= i;
      repeat (2) @(posedge core_clk);
      #1;
      chk("store_q", {48'h0, e}, {48'h0, store_q});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      pack(MRDC_UINT16, MRDC_SCALE_1, 64'h0000_0000_0000_1234, 64'h0000_0000_0000_1234, 4'h2);
      pack(MRDC_INT16, MRDC_SCALE_1, 64'h0000_0000_0000_8001, 64'h0000_0000_0000_8001, 4'h2);
      pack(MRDC_UINT32, MRDC_SCALE_1, 64'h0000_0000_89AB_CDEF, 64'h0000_0000_89AB_CDEF, 4'h4);
      pack(MRDC_INT32, MRDC_SCALE_1, 64'h0000_0000_F123_4567, 64'h0000_0000_F123_4567, 4'h4);
      pack(MRDC_UINT64, MRDC_SCALE_1, 64'h0123_4567_89AB_CDEF, 64'h0123_4567_89AB_CDEF, 4'h8);
      pack(MRDC_INT64, MRDC_SCALE_1, 64'hFEDC_BA98_7654_3210, 64'hFEDC_BA98_7654_3210, 4'h8);
      pack(MRDC_FLOAT32, MRDC_SCALE_1, 64'h0000_0000_BF80_0000, 64'h0000_0000_BF80_0000, 4'h4);
      pack(MRDC_ASCII, MRDC_SCALE_1, 64'h0000_0000_0000_4241, 64'h0000_0000_0000_4241, 4'h2);
      pack(MRDC_BITMAP, MRDC_SCALE_1, 64'h0000_0000_0000_A5A5, 64'h0000_0000_0000_A5A5, 4'h2);
      pack(MRDC_DATETIME, MRDC_SCALE_1, 64'h000D_0C1F_173B_EA5F, 64'h000D_0C1F_173B_EA5F, 4'h8);
      pack(MRDC_UINT16, MRDC_SCALE_10, 64'h0000_0000_0000_007B, 64'h0000_0000_0000_04CE, 4'h2);
      pack(MRDC_UINT16, MRDC_SCALE_TENTH, 64'h0000_0000_0000_04D2, 64'h0000_0000_0000_007B, 4'h2);
      for (int i = 0; i < 7; i++) pack_refused(bad_k[i], bad_v[i]);
      for (int i = 0; i < 4; i++) rx(i[1:0], 16'hFFFF, masks[i]);
      for (int i = 0; i < 7; i++) addr(16'h0079, 4'h3, fcs[i], 1'b1);
      addr(16'h0079, 4'h3, 8'h01, 1'b0);
      addr(16'h1000, 4'hF, 8'h0F, 1'b1);
      addr(16'h1001, 4'h1, 8'h02, 1'b1);
      addr(16'h0BB8, 4'h0, 8'h03, 1'b0);
      st_wr(3'h0, 16'h1111);
      st_wr(3'h1, 16'h2222);
      st_wr(3'h2, 16'h3333);
      st_rd(3'h1, 16'h2222);
      @(posedge core_clk);
      power_loss <= 1'b1;
      @(posedge core_clk);
      power_loss <= 1'b0;
      st_rd(3'h0, 16'h1111);
      st_rd(3'h1, 16'h0000);
      st_rd(3'h2, 16'h3333);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      st_rd(3'h0, 16'h1111);
      st_rd(3'h2, 16'h3333);
      st_rd(3'h1, 16'h0000);
      print_verdict();
   end
endmodule
